// file: design/wcd_clock_select.sv
`default_nettype none
module wcd_clock_select
    import wcd_pkg::*;
(
    input  wire logic       hclk,        // System clock
    input  wire logic       hresetn,     // Async reset, low
    input  wire logic [2:0] osc_in,      // Raw oscillator levels: lfint, mfint, secondary_oscillator
    input  wire logic [2:0] clk_code,    // Effective clock code
    output logic            ref_tick,    // One-cycle pulse per selected rising edge
    output logic            reserved_sel // Reserved code is selected
);
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] last_q;
    logic [2:0] rise;

    // Two-flop synchroniser and edge detect per oscillator
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    last_q[g]  <= 1'b0;
                end
                else
                begin
                    sync1_q[g] <= osc_in[g];
                    sync2_q[g] <= sync1_q[g];
                    last_q[g]  <= sync2_q[g];
                end
            end
            assign rise[g] = sync2_q[g] & ~last_q[g];
        end
    endgenerate

    // Source mux; reserved codes select nothing at all
    always_comb
    begin
        ref_tick     = 1'b0;
        reserved_sel = 1'b0;
        case (clk_code)
            WCD_CLK_LFINT: ref_tick = rise[0];
            WCD_CLK_MFINT: ref_tick = rise[1];
            WCD_CLK_SECONDARY_OSCILLATOR:  ref_tick = rise[2];
            default:       reserved_sel = 1'b1;
        endcase
    end
endmodule : wcd_clock_select
`default_nettype wire

// file: design/wcd_pkg.sv
`default_nettype none
package wcd_pkg;
    // Bus and register geometry
    localparam int          WCD_DATA_W        = 32;
    localparam int          WCD_ADDR_W        = 32;
    localparam int          WCD_CNT_W         = 23;
    // Printed offset is not word aligned, so it is an index; byte address is four times it
    localparam logic [31:0] WCD_CFG_INDEX     = 32'h0000_8009;
    localparam logic [31:0] WCD_CFG_ADDR      = WCD_CFG_INDEX << 2;
    localparam logic [31:0] WCD_CTRL0_ADDR    = 32'h0000_0000;
    localparam logic [31:0] WCD_CTRL1_ADDR    = 32'h0000_0004;
    localparam logic [31:0] WCD_STATUS_ADDR   = 32'h0000_0008;
    // Configuration word fields
    localparam int          WCD_CFG_W         = 14;
    localparam int          WCD_CPS_LSB       = 0;
    localparam int          WCD_MODE_LSB      = 5;
    localparam int          WCD_CWS_LSB       = 8;
    localparam int          WCD_CCS_LSB       = 11;
    localparam logic [13:0] WCD_CFG_RESET     = 14'h3FFF;
    // Control register fields
    localparam int          WCD_SEN_BIT       = 0;
    localparam int          WCD_PER_LSB       = 1;
    localparam int          WCD_RESTART_BIT   = 8;
    localparam int          WCD_WIN_LSB       = 0;
    localparam int          WCD_SWCLK_LSB     = 4;
    // Field codes
    localparam logic [2:0]  WCD_CLK_LFINT     = 3'h0;
    localparam logic [2:0]  WCD_CLK_MFINT     = 3'h1;
    localparam logic [2:0]  WCD_CLK_SECONDARY_OSCILLATOR      = 3'h2;
    localparam logic [2:0]  WCD_CLK_SOFT      = 3'h7;
    localparam logic [2:0]  WCD_WIN_SOFT      = 3'h7;
    localparam logic [2:0]  WCD_WIN_OPEN_MIN  = 3'h6;
    localparam logic [2:0]  WCD_WIN_MAX_SHUT  = 3'h7;
    localparam logic [4:0]  WCD_PER_SOFT      = 5'h1F;
    localparam logic [4:0]  WCD_PER_MAX       = 5'h12;
    localparam logic [4:0]  WCD_PER_SOFT_INIT = 5'h0B;
    localparam logic [4:0]  WCD_EXP_BASE      = 5'h05;
    localparam logic [1:0]  WCD_MODE_ALWAYS   = 2'h3;
    localparam logic [1:0]  WCD_MODE_AWAKE    = 2'h2;
    localparam logic [1:0]  WCD_MODE_SOFT     = 2'h1;
    localparam logic [1:0]  WCD_MODE_OFF      = 2'h0;
    // Reset values of software fields
    localparam logic [2:0]  WCD_SWCLK_RESET   = 3'h0;
    localparam logic        WCD_SEN_RESET     = 1'b0;
endpackage : wcd_pkg
`default_nettype wire

// file: design/wcd_prescaler.sv
`default_nettype none
module wcd_prescaler
    import wcd_pkg::*;
(
    input  wire logic                 hclk,          // System clock
    input  wire logic                 hresetn,       // Async reset, low
    input  wire logic                 ref_tick,      // Reference clock pulse
    input  wire logic                 run,           // Count enable
    input  wire logic                 restart,       // Clear count to zero
    input  wire logic [4:0]           exponent,      // Ratio is two to this power
    input  wire logic [2:0]           shut_eighths,  // Closed part in eighths
    output logic [WCD_CNT_W-1:0]      count_q,       // Current count
    output logic                      period_end_q,  // Pulse at end of period
    output logic                      window_open_q  // Count is past the closed part
);
    logic [23:0] last_val;
    logic [27:0] shut_val;

    // Terminal count and closed threshold scale with the ratio
    assign last_val = (24'h00_0001 << exponent) - 24'h00_0001;
    assign shut_val = {25'h000_0000, shut_eighths} << (exponent - 5'h03);

    // Restart wins over a tick in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_q      <= '0;
            period_end_q <= 1'b0;
        end
        else
        begin
            period_end_q <= 1'b0;
            if (restart)
                count_q <= '0;
            else if (run && ref_tick)
            begin
                if ({1'b0, count_q} >= last_val)
                begin
                    count_q      <= '0;
                    period_end_q <= 1'b1;
                end
                else
                    count_q <= count_q + 23'h00_0001;
            end
        end
    end

    // Window comparison, registered for a clean output
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            window_open_q <= 1'b0;
        else
            window_open_q <= {5'h00, count_q} >= shut_val;
    end
endmodule : wcd_prescaler
`default_nettype wire

// file: design/wcd_top.sv
// Chosen here: the AHB-Lite register port.
`default_nettype none
module wcd_top
    import wcd_pkg::*;
(
    input  wire logic                    hclk,            // Bus clock
    input  wire logic                    hresetn,         // Async reset, low
    input  wire logic                    hsel,            // Slave select
    input  wire logic [WCD_ADDR_W-1:0]   haddr,           // Byte address
    input  wire logic [1:0]              htrans,          // Transfer type
    input  wire logic                    hwrite,          // Write strobe
    input  wire logic [2:0]              hsize,           // Transfer size
    input  wire logic [WCD_DATA_W-1:0]   hwdata,          // Write data
    input  wire logic                    hready,          // Bus ready
    output logic                         hreadyout,       // Slave ready
    output logic                         hresp,           // Always OKAY
    output logic [WCD_DATA_W-1:0]        hrdata,          // Read data
    input  wire logic [WCD_CFG_W-1:0]    config_word,     // Non-volatile word, stable from reset
    input  wire logic                    sleep_req,       // Device in Sleep, same clock
    input  wire logic [2:0]              osc_in,          // Raw oscillator levels
    output logic                         wdt_active,      // Watchdog counting
    output logic                         wdt_period_end,  // Pulse at period end
    output logic                         wdt_window_open, // Clear window open
    output logic                         keyed_access_req // Keyed clear needed
);
    logic [WCD_CFG_W-1:0]   cfg_q;
    logic                   loaded_q;
    logic                   soft_enable_q;
    logic [4:0]             runtime_period_field_q;
    logic [2:0]             window_field_q;
    logic [2:0]             sw_clock_q;
    logic                   restart_q;
    logic                   wr_pend_q;
    logic [WCD_ADDR_W-1:0]  wr_addr_q;
    logic                   hreadyout_q;
    logic [WCD_DATA_W-1:0]  hrdata_q;
    logic                   active_q;
    logic                   keyed_q;
    logic [2:0]             wdt_clock_select;
    logic [2:0]             wdt_window_select;
    logic [1:0]             wdt_operating_mode;
    logic [4:0]             wdt_period_select;
    logic                   window_sw_ctl;
    logic                   period_sw_ctl;
    logic [2:0]             clk_code;
    logic [4:0]             exponent;
    logic [2:0]             shut_eighths;
    logic                   run_d;
    logic                   enabled_d;
    logic                   ref_tick;
    logic                   reserved_sel;
    logic [WCD_CNT_W-1:0]   count;
    logic                   period_end;
    logic                   window_open;
    logic                   addr_phase;
    logic [WCD_DATA_W-1:0]  rd_mux;

    // Field split of the captured configuration
    assign wdt_period_select  = cfg_q[WCD_CPS_LSB +: 5];
    assign wdt_operating_mode = cfg_q[WCD_MODE_LSB +: 2];
    assign wdt_window_select  = cfg_q[WCD_CWS_LSB +: 3];
    assign wdt_clock_select   = cfg_q[WCD_CCS_LSB +: 3];
    assign window_sw_ctl      = (wdt_window_select == WCD_WIN_SOFT);
    assign period_sw_ctl      = (wdt_period_select == WCD_PER_SOFT);

    // Configuration is caught once, on the first edge after reset release
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_q    <= WCD_CFG_RESET;
            loaded_q <= 1'b0;
        end
        else if (!loaded_q)
        begin
            cfg_q    <= config_word;
            loaded_q <= 1'b1;
        end
    end

    // Clock source: software choice only when granted
    assign clk_code = (wdt_clock_select == WCD_CLK_SOFT) ? sw_clock_q : wdt_clock_select;

    // Ratio exponent; out-of-range codes fall back to the shortest period
    always_comb
    begin
        if (runtime_period_field_q <= WCD_PER_MAX)
            exponent = runtime_period_field_q + WCD_EXP_BASE;
        else
            exponent = WCD_EXP_BASE;
    end

    // Closed part of the window in eighths of the period
    always_comb
    begin
        if (window_field_q >= WCD_WIN_OPEN_MIN)
            shut_eighths = 3'h0;
        else
            shut_eighths = WCD_WIN_MAX_SHUT - window_field_q;
    end

    // Operating mode versus Sleep and software enable
    always_comb
    begin
        enabled_d = 1'b0;
        run_d     = 1'b0;
        case (wdt_operating_mode)
            WCD_MODE_ALWAYS:
            begin
                enabled_d = 1'b1;
                run_d     = 1'b1;
            end
            WCD_MODE_AWAKE:
            begin
                enabled_d = 1'b1;
                run_d     = ~sleep_req;
            end
            WCD_MODE_SOFT:
            begin
                enabled_d = soft_enable_q;
                run_d     = soft_enable_q;
            end
            default:
            begin
                enabled_d = 1'b0;
                run_d     = 1'b0;
            end
        endcase
    end

    wcd_clock_select u_clock_select (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .osc_in       (osc_in),
        .clk_code     (clk_code),
        .ref_tick     (ref_tick),
        .reserved_sel (reserved_sel)
    );

    // Disabled counter is held at zero; Sleep suspension keeps the count
    wcd_prescaler u_prescaler (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .ref_tick      (ref_tick),
        .run           (run_d && loaded_q),
        .restart       (restart_q || !enabled_d),
        .exponent      (exponent),
        .shut_eighths  (shut_eighths),
        .count_q       (count),
        .period_end_q  (period_end),
        .window_open_q (window_open)
    );

    // Bus address phase accepted on hready
    assign addr_phase = hsel && htrans[1] && hready;

    // Pending write address; data comes one cycle later
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end
        else
        begin
            wr_pend_q <= addr_phase && hwrite;
            if (addr_phase)
                wr_addr_q <= haddr;
        end
    end

    // Run-time fields: period and window preset from configuration, writable only when granted; enable and clock choice always writable
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            runtime_period_field_q <= WCD_PER_SOFT_INIT;
            window_field_q         <= WCD_WIN_SOFT;
            soft_enable_q          <= WCD_SEN_RESET;
            sw_clock_q             <= WCD_SWCLK_RESET;
        end
        else if (!loaded_q)
        begin
            if (config_word[WCD_CPS_LSB +: 5] == WCD_PER_SOFT)
                runtime_period_field_q <= WCD_PER_SOFT_INIT;
            else
                runtime_period_field_q <= config_word[WCD_CPS_LSB +: 5];
            window_field_q <= config_word[WCD_CWS_LSB +: 3];
        end
        else if (wr_pend_q)
        begin
            if (wr_addr_q == WCD_CTRL0_ADDR)
            begin
                soft_enable_q <= hwdata[WCD_SEN_BIT];
                if (period_sw_ctl)
                    runtime_period_field_q <= hwdata[WCD_PER_LSB +: 5];
            end
            if (wr_addr_q == WCD_CTRL1_ADDR)
            begin
                if (window_sw_ctl)
                    window_field_q <= hwdata[WCD_WIN_LSB +: 3];
                sw_clock_q <= hwdata[WCD_SWCLK_LSB +: 3];
            end
        end
    end

    // Restart is a write-one pulse, never stored
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            restart_q <= 1'b0;
        else
            restart_q <= wr_pend_q && (wr_addr_q == WCD_CTRL0_ADDR) && hwdata[WCD_RESTART_BIT];
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rd_mux = '0;
        case (haddr)
            WCD_CTRL0_ADDR:
            begin
                rd_mux[WCD_SEN_BIT]       = soft_enable_q;
                rd_mux[WCD_PER_LSB +: 5]  = runtime_period_field_q;
            end
            WCD_CTRL1_ADDR:
            begin
                rd_mux[WCD_WIN_LSB +: 3]   = window_field_q;
                rd_mux[WCD_SWCLK_LSB +: 3] = sw_clock_q;
            end
            WCD_STATUS_ADDR:
            begin
                rd_mux[0]     = active_q;
                rd_mux[1]     = window_open;
                rd_mux[2]     = keyed_q;
                rd_mux[3]     = reserved_sel;
                rd_mux[6:4]   = clk_code;
                rd_mux[12:8]  = exponent;
            end
            WCD_CFG_ADDR:
                rd_mux[WCD_CFG_W-1:0] = cfg_q;
            default:
                rd_mux = '0;
        endcase
    end

    // Zero-wait slave: read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_q <= 1'b0;
            hrdata_q    <= '0;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            if (addr_phase && !hwrite)
                hrdata_q <= rd_mux;
        end
    end

    // Status flops feeding the outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            active_q <= 1'b0;
            keyed_q  <= 1'b1;
        end
        else
        begin
            active_q <= run_d && enabled_d && loaded_q && !reserved_sel;
            keyed_q  <= !window_sw_ctl;
        end
    end

    assign hreadyout        = hreadyout_q;
    assign hresp            = 1'b0;
    assign hrdata           = hrdata_q;
    assign wdt_active       = active_q;
    assign wdt_period_end   = period_end;
    assign wdt_window_open  = window_open;
    assign keyed_access_req = keyed_q;

endmodule : wcd_top
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
module testbench import wcd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        sleep_req = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [13:0] config_word = 14'h3FFF;
    logic [4:0]  div_q = 5'h00;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, wdt_active, wdt_period_end, wdt_window_open, keyed_access_req;
    int          error_cnt = 0;
    int          checked = 0;

    // Bus clock
    always #50 hclk = ~hclk;
    // Oscillators at 8, 16 and 32 cycles so each source gives its own period
    always @(posedge hclk) div_q <= div_q + 5'h01;

    wcd_top u_wcd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .config_word(config_word), .sleep_req(sleep_req),
        .osc_in({div_q[4], div_q[3], div_q[2]}), .wdt_active(wdt_active), .wdt_period_end(wdt_period_end),
        .wdt_window_open(wdt_window_open), .keyed_access_req(keyed_access_req));

    task automatic tally_and_finish();
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check_word

    // A wait that runs out counts a mismatch and ends the run
    task automatic time_out(input string name);
        error_cnt++;
        $display("unexpected %s: expected event, seen timeout", name);
        tally_and_finish();
    endtask : time_out

    // Bounded wait for hready at a rising edge
    task automatic wait_ready();
        for (int i = 0; i < 50; i++)
        begin
            @(posedge hclk);
            if (hready_ok()) return;
        end
        time_out("hready");
    endtask : wait_ready

    function automatic bit hready_ok();
        return hreadyout === 1'b1;
    endfunction : hready_ok

    // One idle cycle first, so a read never races the previous write
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check_word(name, exp, q);
        check_word("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask : rd_chk

    task automatic do_reset(input logic [13:0] cfg);
        @(posedge hclk);
        hresetn <= 1'b0;
        config_word <= cfg;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask : do_reset

    // Cycles between period pulses and cycles with the window open
    task automatic measure(input int exp_n, input int exp_open);
        int n;
        int op;
        n = 0;
        op = 0;
        while (wdt_period_end !== 1'b1 && n < 3000)
        begin
            @(posedge hclk);
            n++;
        end
        if (wdt_period_end !== 1'b1)
            time_out("period start");
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
            op += (wdt_window_open === 1'b1);
        end
        while (wdt_period_end !== 1'b1 && n < 3000);
        if (wdt_period_end !== 1'b1)
            time_out("period end");
        check_word("period cycles", exp_n, n);
        check_word("open cycles", exp_open, op);
    endtask : measure

    initial
    begin
        do_reset(14'h3FFF);
        rd_chk("config", WCD_CFG_ADDR, 32'h0000_3FFF);
        rd_chk("status", WCD_STATUS_ADDR, 32'h0000_1003);
        rd_chk("ctrl0", WCD_CTRL0_ADDR, 32'h0000_0016);
        wr(WCD_CTRL0_ADDR, 32'h0000_0000);
        wr(WCD_CTRL1_ADDR, 32'h0000_0020);
        rd_chk("ctrl1", WCD_CTRL1_ADDR, 32'h0000_0020);
        bus(1'b0, WCD_STATUS_ADDR, 32'h0, rd);
        check_word("exponent", 32'h0000_0005, {27'h0, rd[12:8]});
        measure(1024, 128);
        // Restart inside the open part must shut the window again
        for (int i = 0; i < 1100 && wdt_window_open !== 1'b1; i++)
            @(posedge hclk);
        if (wdt_window_open !== 1'b1)
            time_out("window open");
        wr(WCD_CTRL0_ADDR, 32'h0000_0100);
        repeat (3) @(posedge hclk);
        check_word("open after restart", 32'h0000_0000, {31'h0, wdt_window_open});
        wr(WCD_CTRL1_ADDR, 32'h0000_0030);
        bus(1'b0, WCD_STATUS_ADDR, 32'h0, rd);
        check_word("soft reserved", 32'h0000_0038, rd & 32'h0000_0079);
        rd_chk("unmapped", 32'h0000_0040, 32'h0000_0000);
        // Every fixed period code, with a write that must not land
        for (int c = 0; c < 31; c++)
        begin
            do_reset({3'h0, 3'h6, 1'b1, WCD_MODE_OFF, 5'(c)});
            wr(WCD_CTRL0_ADDR, 32'h0000_003E);
            rd_chk("ctrl0 locked", WCD_CTRL0_ADDR, {26'h0, 5'(c), 1'b0});
            bus(1'b0, WCD_STATUS_ADDR, 32'h0, rd);
            check_word("exponent", (c <= 18) ? c + 5 : 5, {27'h0, rd[12:8]});
        end
        // Fixed window codes: locked field, keys, open share of the period
        for (int w = 0; w < 7; w++)
        begin
            do_reset({3'h0, 3'(w), 1'b1, WCD_MODE_ALWAYS, 5'h00});
            wr(WCD_CTRL1_ADDR, 32'h0000_0007);
            rd_chk("ctrl1 locked", WCD_CTRL1_ADDR, 32'(w));
            check_word("keyed", 32'h0000_0001, {31'h0, keyed_access_req});
            measure(256, (w == 6) ? 256 : 256 - 32 * (7 - w));
        end
        // Every non-soft clock code
        for (int k = 0; k < 7; k++)
        begin
            do_reset({3'(k), 3'h6, 1'b1, WCD_MODE_ALWAYS, 5'h00});
            bus(1'b0, WCD_STATUS_ADDR, 32'h0, rd);
            check_word("clock status", ((k < 3) ? 1 : 8) + 16 * k, rd & 32'h0000_0079);
            if (k < 3)
                measure(256 << k, 256 << k);
        end
        // Each operating mode against soft enable and sleep
        for (int m = 0; m < 4; m++)
        begin
            do_reset({3'h0, 3'h6, 1'b1, 2'(m), 5'h00});
            bus(1'b0, WCD_STATUS_ADDR, 32'h0, rd);
            check_word("active", m >= 2, {31'h0, rd[0]});
            wr(WCD_CTRL0_ADDR, 32'h0000_0001);
            bus(1'b0, WCD_STATUS_ADDR, 32'h0, rd);
            check_word("active enabled", m != 0, {31'h0, rd[0]});
            sleep_req <= 1'b1;
            bus(1'b0, WCD_STATUS_ADDR, 32'h0, rd);
            check_word("active sleep", m == 1 || m == 3, {31'h0, rd[0]});
            sleep_req <= 1'b0;
            wr(WCD_CTRL0_ADDR, 32'h0000_0000);
            bus(1'b0, WCD_STATUS_ADDR, 32'h0, rd);
            check_word("active disabled", m >= 2, {31'h0, rd[0]});
        end
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire

// file: verification/wcd_top_chk.sv
`default_nettype none
module wcd_top_chk
    import wcd_pkg::*;
(
    input  wire logic                 hclk,            // Bus clock
    input  wire logic                 hresetn,         // Async reset, low
    input  wire logic [WCD_CFG_W-1:0] config_word,     // Non-volatile word
    input  wire logic                 sleep_req,       // Sleep level
    input  wire logic                 wdt_active,      // Counting
    input  wire logic                 wdt_period_end,  // Period pulse
    input  wire logic                 wdt_window_open, // Clear window open
    input  wire logic                 keyed_access_req // Keyed clear needed
);
    logic [1:0] up_q;
    logic       settled;
    logic       mode_off;
    logic       mode_awake;
    logic       mode_always;

    // Outputs lag capture by a couple of edges, so checks wait for this
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end

    // Decoded operating mode of the captured word
    assign settled     = (up_q == 2'h3);
    assign mode_off    = (config_word[6:5] == WCD_MODE_OFF);
    assign mode_awake  = (config_word[6:5] == WCD_MODE_AWAKE);
    assign mode_always = (config_word[6:5] == WCD_MODE_ALWAYS);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_keyed_map: assert property (settled |-> keyed_access_req == (config_word[10:8] != WCD_WIN_SOFT))
        else $error("keyed flag does not follow window code");
    chk_off_idle: assert property (settled && mode_off |-> !wdt_active && !wdt_period_end)
        else $error("watchdog runs in off mode");
    chk_sleep_halt: assert property ((settled && mode_awake && sleep_req) [*3] |-> !wdt_active && !wdt_period_end)
        else $error("watchdog runs in sleep in awake mode");
    chk_always_run: assert property (settled && mode_always && config_word[13:11] <= WCD_CLK_SECONDARY_OSCILLATOR |-> wdt_active)
        else $error("watchdog stopped in always mode");
    chk_reserved_stop: assert property (settled && config_word[13:11] inside {[3'h3:3'h6]} |-> !wdt_active)
        else $error("reserved clock code runs watchdog");
    chk_pulse_gap: assert property ($rose(wdt_period_end) |=> !wdt_period_end [*8])
        else $error("period pulses too close");
    chk_end_after_open: assert property ($rose(wdt_period_end) |-> $past(wdt_window_open) || $past(wdt_window_open, 2))
        else $error("period ended with window shut");
    chk_full_open: assert property (settled && config_word[10:8] == WCD_WIN_OPEN_MIN |-> wdt_window_open)
        else $error("fully open window reads shut");
endmodule : wcd_top_chk

bind wcd_top wcd_top_chk u_wcd_top_chk (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .config_word      (config_word),
    .sleep_req        (sleep_req),
    .wdt_active       (wdt_active),
    .wdt_period_end   (wdt_period_end),
    .wdt_window_open  (wdt_window_open),
    .keyed_access_req (keyed_access_req)
);
`default_nettype wire
